// ===== core/csub_top.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
// Operation
// - Five independent control switches, each with its own output bit.
// - A switch keeps its state until the opposite command arrives.
// - Only panel or remote link commands change switches; nothing else.
// - Panel command needs session privilege at least the set level, default configurator.
// - On and off transitions raise distinct events; mask keeps on, off or both.
// - Each stored switch event holds the time stamp of the change.
// - Twelve front-panel push buttons, each with its own status.
// - Momentary mode: status active exactly while the button is held.
// - Toggle mode: status inverts once per press.
// - Mode per button selectable, momentary by default after reset.
// - Each button LED lights red, orange or green from status or a chosen signal.
// - Button status changes from the physical panel or a mode register write, never from the remote link.
// - Each button gives complementary on and off outputs.
module csub_top
  import csub_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire csub_cmd_s panel_cmd,
  input wire logic [1:0] panel_priv,
  input wire csub_cmd_s remote_terminal_link_cmd,
  input wire logic [NUM_BTN-1:0] btn_pressed,
  input wire logic [NUM_BTN-1:0] led_ext_sig,
  output logic [NUM_SW-1:0] sw_out,
  output logic [NUM_BTN-1:0] btn_on,
  output logic [NUM_BTN-1:0] btn_off,
  output logic [2*NUM_BTN-1:0] led_color,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  logic [NUM_SW-1:0] sw_ff, nxt_sw;
  logic [NUM_BTN-1:0] btn_mode_ff, nxt_btn_mode;
  logic [NUM_BTN-1:0] tog_ff, nxt_tog;
  logic [NUM_BTN-1:0] btn_prev_ff, nxt_btn_prev;
  logic [NUM_BTN-1:0] btn_on_ff, nxt_btn_on;
  logic [NUM_BTN-1:0] btn_off_ff, nxt_btn_off;
  logic [1:0] ev_mask_ff, nxt_ev_mask;
  logic [1:0] acc_lvl_ff, nxt_acc_lvl;
  logic [2*NUM_BTN-1:0] led_cfg_ff, nxt_led_cfg;
  logic [NUM_BTN-1:0] led_src_ff, nxt_led_src;
  logic [2*NUM_BTN-1:0] led_ff, nxt_led;
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic irq_ff, nxt_irq;
  logic [TS_W-1:0] time_ff, nxt_time;
  csub_ev_s evq_ff [EVQ_DEPTH];
  csub_ev_s nxt_evq [EVQ_DEPTH];
  logic [3:0] evq_cnt_ff, nxt_evq_cnt;
  logic [31:0] rdata_ff, nxt_rdata;

  // Event ring read side is always entry 0; pops shift the queue down
  function automatic logic [31:0] ev_word(input csub_ev_s e, input logic [3:0] cnt);
    ev_word = {cnt != 4'h0, 26'h0, e.idx, e.on, 1'b0};
  endfunction : ev_word

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [NUM_SW-1:0] req_on;
    logic [NUM_SW-1:0] req_off;
    logic pop;
    logic push;
    logic deny;
    logic ovfl;
    csub_ev_s new_ev;
    logic [IRQ_W-1:0] set_bits;
    req_on = '0;
    req_off = '0;
    pop = 1'b0;
    push = 1'b0;
    deny = 1'b0;
    ovfl = 1'b0;
    new_ev = '0;
    set_bits = '0;
    nxt_btn_mode = btn_mode_ff;
    nxt_ev_mask = ev_mask_ff;
    nxt_acc_lvl = acc_lvl_ff;
    nxt_led_cfg = led_cfg_ff;
    nxt_led_src = led_src_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_time = time_ff + 32'h1;
    nxt_evq = evq_ff;
    nxt_evq_cnt = evq_cnt_ff;
    nxt_rdata = 32'h0;

    // Switches: remote link takes precedence if both arrive together
    if (remote_terminal_link_cmd.valid && remote_terminal_link_cmd.idx < 3'(NUM_SW)) begin
      req_on[remote_terminal_link_cmd.idx] = remote_terminal_link_cmd.on;
      req_off[remote_terminal_link_cmd.idx] = !remote_terminal_link_cmd.on;
    end else if (panel_cmd.valid && panel_cmd.idx < 3'(NUM_SW)) begin
      if (panel_priv >= acc_lvl_ff) begin
        req_on[panel_cmd.idx] = panel_cmd.on;
        req_off[panel_cmd.idx] = !panel_cmd.on;
      end else begin
        deny = 1'b1;
      end
    end
    nxt_sw = (sw_ff | req_on) & ~req_off;

    // One change per cycle at most, so a single event slot suffices
    for (int i = 0; i < NUM_SW; i++) begin
      if (req_on[i] && !sw_ff[i] && ev_mask_ff[EVM_ON_POS]) begin
        push = 1'b1;
        new_ev = '{stamp: time_ff, idx: 3'(i), on: 1'b1};
      end
      if (req_off[i] && sw_ff[i] && ev_mask_ff[EVM_OFF_POS]) begin
        push = 1'b1;
        new_ev = '{stamp: time_ff, idx: 3'(i), on: 1'b0};
      end
    end

    // Register reads: event time must be read before the pop word
    if (reg_rd) begin
      if (reg_addr == ADDR_SW_STATE) begin
        nxt_rdata = 32'(sw_ff);
      end else if (reg_addr == ADDR_BTN_MODE) begin
        nxt_rdata = 32'(btn_mode_ff);
      end else if (reg_addr == ADDR_BTN_STATE) begin
        nxt_rdata = 32'(btn_on_ff);
      end else if (reg_addr == ADDR_EV_MASK) begin
        nxt_rdata = 32'(ev_mask_ff);
      end else if (reg_addr == ADDR_ACC_LVL) begin
        nxt_rdata = 32'(acc_lvl_ff);
      end else if (reg_addr == ADDR_LED_CFG) begin
        nxt_rdata = 32'(led_cfg_ff);
      end else if (reg_addr == ADDR_LED_SRC) begin
        nxt_rdata = 32'(led_src_ff);
      end else if (reg_addr == ADDR_IRQ_STAT) begin
        nxt_rdata = 32'(irq_stat_ff);
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        nxt_rdata = 32'(irq_mask_ff);
      end else if (reg_addr == ADDR_EV_POP) begin
        nxt_rdata = ev_word(evq_ff[0], evq_cnt_ff);
        pop = (evq_cnt_ff != 4'h0);
      end else if (reg_addr == ADDR_EV_TIME) begin
        nxt_rdata = evq_ff[0].stamp;
      end else if (reg_addr == ADDR_TIME_NOW) begin
        nxt_rdata = time_ff;
      end else begin
        nxt_rdata = 32'h0;
      end
    end

    // Register writes; switch state is deliberately not writable here
    if (reg_wr) begin
      if (reg_addr == ADDR_BTN_MODE) begin
        nxt_btn_mode = reg_wdata[NUM_BTN-1:0];
      end else if (reg_addr == ADDR_EV_MASK) begin
        nxt_ev_mask = reg_wdata[1:0];
      end else if (reg_addr == ADDR_ACC_LVL) begin
        nxt_acc_lvl = reg_wdata[1:0];
      end else if (reg_addr == ADDR_LED_CFG) begin
        nxt_led_cfg = reg_wdata[2*NUM_BTN-1:0];
      end else if (reg_addr == ADDR_LED_SRC) begin
        nxt_led_src = reg_wdata[NUM_BTN-1:0];
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        nxt_irq_mask = reg_wdata[IRQ_W-1:0];
      end
    end

    // Queue: pop shifts, push lands at the new tail; full drops the newest
    if (pop) begin
      for (int k = 0; k < EVQ_DEPTH - 1; k++) begin
        nxt_evq[k] = evq_ff[k+1];
      end
      nxt_evq_cnt = evq_cnt_ff - 4'h1;
    end
    if (push) begin
      if (nxt_evq_cnt < 4'(EVQ_DEPTH)) begin
        nxt_evq[nxt_evq_cnt[2:0]] = new_ev;
        nxt_evq_cnt = nxt_evq_cnt + 4'h1;
      end else begin
        ovfl = 1'b1;
      end
    end

    // Sticky status: a new event wins over a simultaneous clear
    set_bits[IRQ_EVENT_POS] = push;
    set_bits[IRQ_OVFL_POS] = ovfl;
    set_bits[IRQ_DENY_POS] = deny;
    nxt_irq_stat = irq_stat_ff;
    if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | set_bits;
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  // ****************************************
  // Button next-state logic
  // ****************************************
  // Panel lines, the mode register and the LED registers reach this state; no link path
  always_comb begin
    logic [NUM_BTN-1:0] btn_stat;
    btn_stat = '0;
    nxt_btn_prev = btn_pressed;
    for (int b = 0; b < NUM_BTN; b++) begin
      // Presses in momentary mode leave the toggle memory alone
      nxt_tog[b] = tog_ff[b] ^ (btn_mode_ff[b] & btn_pressed[b] & ~btn_prev_ff[b]);
      if (btn_mode_ff[b]) begin
        btn_stat[b] = nxt_tog[b];
      end else begin
        btn_stat[b] = btn_pressed[b];
      end
      nxt_btn_on[b] = btn_stat[b];
      nxt_btn_off[b] = !btn_stat[b];
      if (led_src_ff[b]) begin
        nxt_led[2*b +: 2] = led_ext_sig[b] ? led_cfg_ff[2*b +: 2] : LED_OFF;
      end else begin
        nxt_led[2*b +: 2] = btn_stat[b] ? led_cfg_ff[2*b +: 2] : LED_OFF;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Switch state and the free-running stamp counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_ff <= '0;
      time_ff <= '0;
    end else begin
      sw_ff <= nxt_sw;
      time_ff <= nxt_time;
    end
  end

  // Button status and indicator drive
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_ff <= '0;
      btn_prev_ff <= '0;
      btn_on_ff <= '0;
      btn_off_ff <= '1;
      led_ff <= '0;
    end else begin
      tog_ff <= nxt_tog;
      btn_prev_ff <= nxt_btn_prev;
      btn_on_ff <= nxt_btn_on;
      btn_off_ff <= nxt_btn_off;
      led_ff <= nxt_led;
    end
  end

  // Software settings
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_mode_ff <= BTN_MODE_RST;
      ev_mask_ff <= EV_MASK_RST;
      acc_lvl_ff <= ACC_LVL_RST;
      led_cfg_ff <= LED_CFG_RST;
      led_src_ff <= LED_SRC_RST;
      irq_mask_ff <= '0;
    end else begin
      btn_mode_ff <= nxt_btn_mode;
      ev_mask_ff <= nxt_ev_mask;
      acc_lvl_ff <= nxt_acc_lvl;
      led_cfg_ff <= nxt_led_cfg;
      led_src_ff <= nxt_led_src;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // Event queue
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evq_cnt_ff <= '0;
      for (int k = 0; k < EVQ_DEPTH; k++) begin
        evq_ff[k] <= '0;
      end
    end else begin
      evq_cnt_ff <= nxt_evq_cnt;
      evq_ff <= nxt_evq;
    end
  end

  // Status, interrupt line and read data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sw_out = sw_ff;
  assign btn_on = btn_on_ff;
  assign btn_off = btn_off_ff;
  assign led_color = led_ff;
  assign irq = irq_ff;
  assign reg_rdata = rdata_ff;

endmodule : csub_top

// ===== core/csub_pkg.sv
package csub_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SW = 5;
  localparam int NUM_BTN = 12;
  localparam int TS_W = 32;
  localparam int EVQ_DEPTH = 8;

  // ****************************************
  // Register map (byte addresses, byte = 4 x word index)
  // ****************************************
  localparam logic [7:0] ADDR_SW_STATE = 8'h00;
  localparam logic [7:0] ADDR_BTN_MODE = 8'h04;
  localparam logic [7:0] ADDR_BTN_STATE = 8'h08;
  localparam logic [7:0] ADDR_EV_MASK = 8'h0c;
  localparam logic [7:0] ADDR_ACC_LVL = 8'h10;
  localparam logic [7:0] ADDR_LED_CFG = 8'h14;
  localparam logic [7:0] ADDR_LED_SRC = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADDR_EV_POP = 8'h24;
  localparam logic [7:0] ADDR_EV_TIME = 8'h28;
  localparam logic [7:0] ADDR_TIME_NOW = 8'h2c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EVM_ON_POS = 0;
  localparam int EVM_OFF_POS = 1;
  localparam int IRQ_EVENT_POS = 0;
  localparam int IRQ_OVFL_POS = 1;
  localparam int IRQ_DENY_POS = 2;
  localparam int IRQ_W = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] EV_MASK_RST = 2'h3;
  localparam logic [1:0] ACC_LVL_RST = 2'h2;
  localparam logic [NUM_BTN-1:0] BTN_MODE_RST = 12'h000;
  localparam logic [2*NUM_BTN-1:0] LED_CFG_RST = 24'h000000;
  localparam logic [NUM_BTN-1:0] LED_SRC_RST = 12'h000;

  typedef enum logic [1:0] {
    ACC_USER = 2'b00,
    ACC_OPER = 2'b01,
    ACC_CONF = 2'b10,
    ACC_SUPER = 2'b11
  } csub_acc_e;

  typedef enum logic [1:0] {
    LED_OFF = 2'b00,
    LED_RED = 2'b01,
    LED_ORANGE = 2'b10,
    LED_GREEN = 2'b11
  } csub_led_e;

  // One switch command from the panel or the remote link
  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    logic on;
  } csub_cmd_s;

  // One stored switch event
  typedef struct packed {
    logic [TS_W-1:0] stamp;
    logic [2:0] idx;
    logic on;
  } csub_ev_s;

endpackage : csub_pkg

// ===== verification/csub_props.sv
`timescale 1ns/10ps
module csub_props
  import csub_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire csub_cmd_s panel_cmd,
  input wire logic [1:0] panel_priv,
  input wire csub_cmd_s remote_terminal_link_cmd,
  input wire logic [NUM_BTN-1:0] btn_pressed,
  input wire logic [NUM_SW-1:0] sw_out,
  input wire logic [NUM_BTN-1:0] btn_on,
  input wire logic [NUM_BTN-1:0] btn_off
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Any mode write ends the momentary-only window, even a write of zero
  logic mode_wr_ff;
  logic nxt_mode_wr;
  always_comb nxt_mode_wr = mode_wr_ff | (reg_wr && reg_addr == ADDR_BTN_MODE);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) mode_wr_ff <= 1'b0;
    else mode_wr_ff <= nxt_mode_wr;
  end
  sequence s_rcmd;
    remote_terminal_link_cmd.valid && remote_terminal_link_cmd.idx < 3'h5;
  endsequence
  sequence s_pcmd;
    panel_cmd.valid && !remote_terminal_link_cmd.valid && panel_cmd.idx < 3'h5
      && panel_priv == 2'h3;
  endsequence
  property p_remote;
    s_rcmd |=> sw_out[$past(remote_terminal_link_cmd.idx)] == $past(remote_terminal_link_cmd.on);
  endproperty
  property p_panel;
    s_pcmd |=> sw_out[$past(panel_cmd.idx)] == $past(panel_cmd.on);
  endproperty
  property p_hold;
    !panel_cmd.valid && !remote_terminal_link_cmd.valid |=> $stable(sw_out);
  endproperty
  property p_compl;
    btn_off == ~btn_on;
  endproperty
  property p_self_on;
    (btn_on & ~$past(btn_on) & ~$past(btn_pressed)) == '0;
  endproperty
  property p_rst;
    $rose(rst_n) |-> sw_out == '0 && btn_off == '1;
  endproperty
  property p_rd;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  property p_mom;
    !mode_wr_ff && $past(rst_n) |-> btn_on == $past(btn_pressed);
  endproperty
  a_remote: assert property (p_remote) else $error("remote command not applied");
  a_panel: assert property (p_panel) else $error("panel command not applied");
  a_hold: assert property (p_hold) else $error("switch moved without command");
  a_compl: assert property (p_compl) else $error("button outputs not complementary");
  a_self_on: assert property (p_self_on) else $error("button on without press");
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  a_rd: assert property (p_rd) else $error("read data outside read slot");
  a_mom: assert property (p_mom) else $error("momentary status wrong");
endmodule : csub_props

bind csub_top csub_props u_props (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .panel_cmd, .panel_priv, .remote_terminal_link_cmd, .btn_pressed, .sw_out, .btn_on, .btn_off);

// ===== verification/csub_panel_model.sv
`timescale 1ns/10ps
module csub_panel_model
  import csub_pkg::*;
(
  input wire logic core_clk,
  output csub_cmd_s panel_cmd,
  output logic [1:0] panel_priv,
  output csub_cmd_s remote_terminal_link_cmd
);
  // ****
  // Panel and remote link commands
  // ****
  initial begin
    panel_cmd = '0;
    remote_terminal_link_cmd = '0;
    panel_priv = 2'h0;
  end
  // Idle fields show inverted values so a design ignoring valid is caught
  task send(input logic rem, input logic [2:0] idx, input logic on, input logic [1:0] priv,
    input int gap);
    csub_cmd_s c;
    c = '{valid: 1'b1, idx: idx, on: on};
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    if (rem) remote_terminal_link_cmd <= c;
    else panel_cmd <= c;
    panel_priv <= priv;
    @(posedge core_clk);
    c = '{valid: 1'b0, idx: ~idx, on: ~on};
    remote_terminal_link_cmd <= c;
    panel_cmd <= c;
  endtask : send
endmodule : csub_panel_model

// ===== verification/tb_csub_top.sv
`timescale 1ns/10ps
module tb_csub_top import csub_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  csub_cmd_s panel_cmd;
  csub_cmd_s remote_terminal_link_cmd;
  logic [1:0] panel_priv;
  logic [NUM_BTN-1:0] btn_pressed;
  logic [NUM_BTN-1:0] led_ext_sig;
  logic [NUM_BTN-1:0] btn_on;
  logic [NUM_BTN-1:0] btn_off;
  logic [NUM_SW-1:0] sw_out;
  logic [2*NUM_BTN-1:0] led_color;
  logic irq;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  always #10 core_clk = ~core_clk;
  csub_top DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .panel_cmd, .panel_priv, .remote_terminal_link_cmd, .btn_pressed, .led_ext_sig, .sw_out,
    .btn_on, .btn_off, .led_color, .irq);
  csub_panel_model PM (.core_clk, .panel_cmd, .panel_priv, .remote_terminal_link_cmd);
  // ****
  // Access tasks
  // ****
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask : rd
  task btn(input logic [11:0] v);
    @(posedge core_clk);
    btn_pressed <= v;
    @(posedge core_clk);
    #1;
  endtask : btn
  task conclude;
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Run is about 90 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    btn_pressed = 12'h000;
    led_ext_sig = 12'h002;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk("sw", 32'h0, sw_out);
    chk("off", 32'hfff, btn_off);
    rd(ADDR_EV_MASK, 32'h3);
    rd(ADDR_ACC_LVL, 32'h2);
    rd(ADDR_BTN_MODE, 32'h0);
    rd(8'hfc, 32'h0);
    PM.send(1'b1, 3'h2, 1'b1, 2'h0, 0);
    #1 chk("sw", 32'h04, sw_out);
    rd(ADDR_IRQ_STAT, 32'h1);
    chk("irq", 32'h0, irq);
    rd(ADDR_EV_TIME, 32'h9);
    rd(ADDR_TIME_NOW, 32'hf);
    rd(ADDR_EV_POP, 32'h8000000a);
    PM.send(1'b1, 3'h2, 1'b1, 2'h0, 2);
    #1 chk("sw", 32'h04, sw_out);
    rd(ADDR_EV_POP, 32'h0);
    PM.send(1'b0, 3'h0, 1'b1, 2'h1, 0);
    #1 chk("sw", 32'h04, sw_out);
    rd(ADDR_IRQ_STAT, 32'h5);
    PM.send(1'b0, 3'h0, 1'b1, 2'h2, 0);
    PM.send(1'b0, 3'h5, 1'b1, 2'h3, 0);
    #1 chk("sw", 32'h05, sw_out);
    rd(ADDR_EV_POP, 32'h80000002);
    wr(ADDR_EV_MASK, 32'h1);
    PM.send(1'b1, 3'h2, 1'b0, 2'h0, 0);
    #1 chk("sw", 32'h01, sw_out);
    rd(ADDR_EV_POP, 32'h0);
    wr(ADDR_SW_STATE, 32'h1f);
    wr(ADDR_IRQ_MASK, 32'h1);
    rd(ADDR_SW_STATE, 32'h1);
    chk("irq", 32'h1, irq);
    wr(ADDR_IRQ_STAT, 32'h7);
    rd(ADDR_IRQ_STAT, 32'h0);
    chk("irq", 32'h0, irq);
    btn(12'h801);
    chk("on", 32'h801, btn_on);
    chk("off", 32'h7fe, btn_off);
    btn(12'h000);
    chk("on", 32'h0, btn_on);
    wr(ADDR_BTN_MODE, 32'h1);
    wr(ADDR_LED_CFG, 32'h7);
    wr(ADDR_LED_SRC, 32'h2);
    btn(12'h001);
    chk("on", 32'h1, btn_on);
    btn(12'h000);
    rd(ADDR_BTN_STATE, 32'h1);
    chk("led", 32'h7, led_color);
    btn(12'h001);
    chk("on", 32'h0, btn_on);
    PM.send(1'b0, 3'h0, 1'b0, 2'h3, 0);
    #1 chk("sw", 32'h0, sw_out);
    conclude();
  end
endmodule : tb_csub_top
